// [bcp_pkg.sv]
// Behaviour
// - chop only high-side outputs, low-side static
// - over-limit current cuts drive for this period
// - blank limit sensing after PWM turn-on
// - PWM period timebase clocks internal logic
// - control voltage sets duty, 1.35V to 3.0V
// - pulse duty input low enables drive
// - equal Hall inputs force all six phase drive outputs low
// - under-voltage stops high side, hysteretic recovery
// - one timer reset per Hall period
// - stalled: alternate drive-on and drive-off intervals
// - stall cycling gates only high-side outputs
// - Hall activity exits stall; disable bit
// - direction change inserts dead time
// - Hall pattern and direction select phase pair
// - Hall pulse output: synthesized or single
// - rotation detect on while turning
package bcp_pkg;
   localparam int CLK_MHZ = 100;
   localparam int PWM_FREQ_HZ = 22000;
   localparam int PWM_PERIOD_CYC = (CLK_MHZ * 1000000) / PWM_FREQ_HZ;
   localparam int BLANK_NS = 1000;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int DEAD_NS = 2000;
   localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int DEBOUNCE_NS = 500;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
   localparam int LOCK_ON_MS = 418;
   localparam int LOCK_OFF_MS = 6251;
   localparam int LOCK_ON_CYC = LOCK_ON_MS * CLK_MHZ * 1000;
   localparam int LOCK_OFF_CYC = LOCK_OFF_MS * CLK_MHZ * 1000;
   localparam logic [11:0] VC_ZERO_MV = 12'h546;
   localparam logic [11:0] VC_FULL_MV = 12'hbb8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] VCTL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [31:0] CTRL_RST = 32'h00000001;
   localparam logic [11:0] VCTL_RST = 12'h000;
   localparam int CTRL_LOCK_EN = 0;
   localparam int PIN_DIR = 0;
   localparam int PIN_PDI = 1;
   localparam int PIN_SEL = 2;
   localparam int PIN_ILIM = 3;
   localparam int PIN_UVLO = 4;
   localparam int PIN_UVOK = 5;
   localparam logic [5:0] PIN_RST = 6'h06;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } bcp_apb_req_type;

   typedef enum logic [1:0] {LOCK_RUN, LOCK_OFF, LOCK_ON} bcp_lock_type;
endpackage

// [bcp_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
module bcp_debounce #(
   parameter int W = 3,
   parameter int N = 50
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset
   input wire logic ce, // clock enable
   input wire logic [W-1:0] raw, // pin inputs
   output logic [W-1:0] stable // filtered level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] stable;
      logic [7:0] cnt;
   } bcp_deb_type;

   bcp_deb_type q, d;

   always_comb begin
      d = q;
      d.s1 = raw;
      d.s2 = q.s1;
      if (q.s2 == q.stable) begin
         d.cnt = '0;
      end else if (q.cnt == 8'(N - 1)) begin
         d.stable = q.s2;
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign stable = q.stable;
endmodule
`default_nettype wire

// [bcp_predriver.sv]
`timescale 1ns/1ps
`default_nettype none
module bcp_predriver #(
   parameter int PWM_PERIOD = bcp_pkg::PWM_PERIOD_CYC,
   parameter int LOCK_ON = bcp_pkg::LOCK_ON_CYC,
   parameter int LOCK_OFF = bcp_pkg::LOCK_OFF_CYC
) (
   input wire logic pclk, // pwm timebase clock
   input wire logic presetn, // async reset, low
   input wire logic ce, // clock enable
   input wire bcp_pkg::bcp_apb_req_type apb_req, // apb request
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [2:0] hall_in, // hall sensors 1..3
   input wire logic direction, // forward/reverse
   input wire logic pulse_duty_input, // low enables drive
   input wire logic hall_output_select, // high: synthesized
   input wire logic current_limit_trip, // sense above limit
   input wire logic supply_below_trip, // under-voltage
   input wire logic supply_above_recover, // trip plus hysteresis
   output logic phase_a_high_drive, // high side a
   output logic phase_b_high_drive, // high side b
   output logic phase_c_high_drive, // high side c
   output logic phase_a_low_drive, // low side a
   output logic phase_b_low_drive, // low side b
   output logic phase_c_low_drive, // low side c
   output logic hall_pulse_output, // hall pulse
   output logic rotation_detect_oe // pulls pin low: turning
);
   typedef struct packed {
      logic [5:0] pin_s1;
      logic [5:0] pin_s2;
      logic [31:0] pwm_cnt;
      logic [7:0] blank_cnt;
      logic limit;
      logic [2:0] hall_prev;
      bcp_pkg::bcp_lock_type state;
      logic [31:0] lock_cnt;
      logic dir_prev;
      logic [15:0] dead_cnt;
      logic uv;
      logic lock_en;
      logic [11:0] vctl;
      logic [2:0] hi;
      logic [2:0] lo;
      logic hp;
      logic rot_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } bcp_state_type;

   bcp_state_type q, d;
   logic [2:0] hall;
   logic [2:0] h_eff;
   logic [5:0] pair;
   logic valid;
   logic period_start;
   logic hall_period;
   logic hall_move;
   logic ramp_on;
   logic hs_gate;
   logic lo_ok;
   logic [31:0] lhs;
   logic [31:0] rhs;
   logic setup;
   logic wr;
   logic mapped;

   bcp_debounce #(
      .W(3),
      .N(bcp_pkg::DEBOUNCE_CYC)
   ) u_hall_deb (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .raw(hall_in),
      .stable(hall)
   );

   // {a,b,c} high then {a,b,c} low
   function automatic logic [5:0] commutate(input logic [2:0] h);
      case (h)
         3'b101: commutate = {3'b010, 3'b100};
         3'b100: commutate = {3'b001, 3'b100};
         3'b110: commutate = {3'b001, 3'b010};
         3'b010: commutate = {3'b100, 3'b010};
         3'b011: commutate = {3'b100, 3'b001};
         3'b001: commutate = {3'b010, 3'b001};
         default: commutate = 6'h00;
      endcase
   endfunction

   always_comb begin
      d = q;
      d.pin_s1 = {supply_above_recover, supply_below_trip,
                  current_limit_trip, hall_output_select,
                  pulse_duty_input, direction};
      d.pin_s2 = q.pin_s1;
      // pwm timebase
      period_start = (q.pwm_cnt == 32'(PWM_PERIOD - 1));
      d.pwm_cnt = period_start ? 32'h0 : q.pwm_cnt + 32'h1;
      // duty from control voltage against ramp
      lhs = 32'(({20'h0, q.vctl} - {20'h0, bcp_pkg::VC_ZERO_MV})
                * 32'(PWM_PERIOD));
      rhs = 32'(q.pwm_cnt * 32'(bcp_pkg::VC_FULL_MV
                                 - bcp_pkg::VC_ZERO_MV));
      if (q.vctl <= bcp_pkg::VC_ZERO_MV) begin
         ramp_on = 1'b0;
      end else if (q.vctl >= bcp_pkg::VC_FULL_MV) begin
         ramp_on = 1'b1;
      end else begin
         ramp_on = lhs > rhs;
      end
      // current limit, blanked after each turn-on
      if (period_start) begin
         d.limit = 1'b0;
         d.blank_cnt = 8'(bcp_pkg::BLANK_CYC);
      end else begin
         if (q.blank_cnt != 8'h0) begin
            d.blank_cnt = q.blank_cnt - 8'h01;
         end
         if (q.blank_cnt == 8'h0 && q.pin_s2[bcp_pkg::PIN_ILIM]) begin
            d.limit = 1'b1;
         end
      end
      // hall handling
      d.hall_prev = hall;
      hall_move = hall != q.hall_prev;
      hall_period = hall[2] & ~q.hall_prev[2];
      valid = (hall != 3'b000) && (hall != 3'b111);
      h_eff = q.pin_s2[bcp_pkg::PIN_DIR] ? ~hall : hall;
      pair = commutate(h_eff);
      // lock protection timer
      d.lock_cnt = q.lock_cnt + 32'h1;
      case (q.state)
         bcp_pkg::LOCK_RUN: begin
            if (q.lock_cnt == 32'(LOCK_ON - 1)) begin
               d.state = bcp_pkg::LOCK_OFF;
               d.lock_cnt = 32'h0;
            end
         end
         bcp_pkg::LOCK_OFF: begin
            if (q.lock_cnt == 32'(LOCK_OFF - 1)) begin
               d.state = bcp_pkg::LOCK_ON;
               d.lock_cnt = 32'h0;
            end
         end
         bcp_pkg::LOCK_ON: begin
            if (q.lock_cnt == 32'(LOCK_ON - 1)) begin
               d.state = bcp_pkg::LOCK_OFF;
               d.lock_cnt = 32'h0;
            end
         end
         default: begin
            d.state = bcp_pkg::LOCK_RUN;
         end
      endcase
      if (!q.lock_en || hall_period ||
          (hall_move && q.state != bcp_pkg::LOCK_RUN)) begin
         d.state = bcp_pkg::LOCK_RUN;
         d.lock_cnt = 32'h0;
      end
      // direction change dead time
      d.dir_prev = q.pin_s2[bcp_pkg::PIN_DIR];
      if (q.pin_s2[bcp_pkg::PIN_DIR] != q.dir_prev) begin
         d.dead_cnt = 16'(bcp_pkg::DEAD_CYC);
      end else if (q.dead_cnt != 16'h0) begin
         d.dead_cnt = q.dead_cnt - 16'h1;
      end
      // under-voltage with hysteresis
      if (q.pin_s2[bcp_pkg::PIN_UVLO]) begin
         d.uv = 1'b1;
      end else if (q.pin_s2[bcp_pkg::PIN_UVOK]) begin
         d.uv = 1'b0;
      end
      // output gating
      lo_ok = valid && q.dead_cnt == 16'h0;
      hs_gate = ramp_on && !q.pin_s2[bcp_pkg::PIN_PDI] && !q.limit
                && !q.uv && q.state != bcp_pkg::LOCK_OFF
                && lo_ok;
      d.hi = pair[5:3] & {3{hs_gate}};
      d.lo = pair[2:0] & {3{lo_ok}};
      d.hp = q.pin_s2[bcp_pkg::PIN_SEL] ? ^hall : hall[2];
      d.rot_oe = q.state == bcp_pkg::LOCK_RUN;
      // apb slave, answer in first access cycle
      setup = apb_req.psel && !apb_req.penable;
      wr = apb_req.psel && apb_req.penable && apb_req.pwrite && q.pready;
      mapped = apb_req.paddr == bcp_pkg::CTRL_OFS ||
               apb_req.paddr == bcp_pkg::VCTL_OFS ||
               apb_req.paddr == bcp_pkg::STAT_OFS;
      d.pready = setup;
      d.pslverr = setup && !mapped;
      d.prdata = 32'h0;
      if (setup && !apb_req.pwrite) begin
         case (apb_req.paddr)
            bcp_pkg::CTRL_OFS: d.prdata = {31'h0, q.lock_en};
            bcp_pkg::VCTL_OFS: d.prdata = {20'h0, q.vctl};
            bcp_pkg::STAT_OFS: d.prdata = {24'h0, q.uv, q.limit,
                                           q.state != bcp_pkg::LOCK_RUN,
                                           q.pin_s2[bcp_pkg::PIN_DIR],
                                           valid, hall};
            default: d.prdata = 32'h0;
         endcase
      end
      if (wr && !q.pslverr) begin
         if (apb_req.paddr == bcp_pkg::CTRL_OFS) begin
            d.lock_en = apb_req.pwdata[bcp_pkg::CTRL_LOCK_EN];
         end
         if (apb_req.paddr == bcp_pkg::VCTL_OFS) begin
            d.vctl = apb_req.pwdata[11:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.lock_en <= bcp_pkg::CTRL_RST[bcp_pkg::CTRL_LOCK_EN];
         q.vctl <= bcp_pkg::VCTL_RST;
         q.pin_s1 <= bcp_pkg::PIN_RST;
         q.pin_s2 <= bcp_pkg::PIN_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign phase_a_high_drive = q.hi[2];
   assign phase_b_high_drive = q.hi[1];
   assign phase_c_high_drive = q.hi[0];
   assign phase_a_low_drive = q.lo[2];
   assign phase_b_low_drive = q.lo[1];
   assign phase_c_low_drive = q.lo[0];
   assign hall_pulse_output = q.hp;
   assign rotation_detect_oe = q.rot_oe;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn || !ce);

   sequence s_dir_flip;
      q.pin_s2[bcp_pkg::PIN_DIR] != q.dir_prev;
   endsequence

   sequence s_dead_blank;
      q.dead_cnt == 16'(bcp_pkg::DEAD_CYC) ##1 (q.hi == 3'b000
                                                && q.lo == 3'b000);
   endsequence

   chk_high_pairs_low: assert property (
      (q.hi != 3'b000) |-> (q.lo != 3'b000 && (q.hi & q.lo) == 3'b000))
      else $error("high drive without a low partner");
   chk_limit_cut: assert property (
      (q.limit && !period_start) |=> q.hi == 3'b000)
      else $error("high drive during current limit");
   chk_blank_window: assert property (
      (q.blank_cnt != 8'h0 && !q.limit) |=> !q.limit)
      else $error("limit set inside blanking window");
   chk_pulse_off: assert property (
      q.pin_s2[bcp_pkg::PIN_PDI] |=> q.hi == 3'b000)
      else $error("drive on while pulse input high");
   chk_hall_invalid: assert property (
      (hall == 3'b000 || hall == 3'b111) |=> (q.hi | q.lo) == 3'b000)
      else $error("outputs on with invalid hall");
   chk_uv_off: assert property (
      q.uv |=> q.hi == 3'b000)
      else $error("high drive during under-voltage");
   chk_stall_entry: assert property (
      (q.state == bcp_pkg::LOCK_RUN && d.state == bcp_pkg::LOCK_OFF)
      |-> q.lock_cnt == 32'(LOCK_ON - 1))
      else $error("stall entered at wrong count");
   chk_stall_off: assert property (
      (q.state == bcp_pkg::LOCK_OFF) |=> q.hi == 3'b000)
      else $error("high drive in stall off interval");
   chk_dead_time: assert property (
      s_dir_flip |=> s_dead_blank)
      else $error("no dead time after direction change");
   chk_hp_select: assert property (
      ce |=> q.hp == ($past(q.pin_s2[bcp_pkg::PIN_SEL]) ?
                      ^$past(hall) : $past(hall[2])))
      else $error("hall pulse output wrong");
   chk_rot_detect: assert property (
      (q.state != bcp_pkg::LOCK_RUN) |=> !q.rot_oe)
      else $error("rotation detect on while stalled");
endmodule
`default_nettype wire

// [bcp_motor_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bcp_motor_model (
   input wire logic pclk, // sample clock
   input wire logic [2:0] target, // commanded rotor position
   output logic [2:0] hall_in // sensor levels
);
   logic [2:0] pos_q = 3'h5;
   int chat_q = 0;
   initial hall_in = 3'h5;
   // sensors chatter through the inverse code before settling
   always @(posedge pclk) begin
      if (target !== pos_q) begin
         pos_q <= target;
         chat_q <= 7;
      end else if (chat_q > 0) begin
         chat_q <= chat_q - 1;
      end
      hall_in <= (chat_q > 1 && chat_q[0]) ? ~pos_q : pos_q;
   end
endmodule
`default_nettype wire

// [bldc_commutation_predriver_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module bldc_commutation_predriver_tb;
   localparam int PER = 256;
   logic pclk = 0;
   logic presetn = 0;
   logic ce = 1;
   bcp_pkg::bcp_apb_req_type req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] hall_t = 3'h5;
   logic [2:0] hall;
   logic dir = 0;
   logic pdi = 0;
   logic sel = 1;
   logic trip = 0;
   logic below = 0;
   logic recov = 1;
   logic ah, bh, chh, al, bl, cl, hp, rot;
   logic smp = 0;
   logic [32:0] rq[$];
   logic [7:0] dq[$];
   logic [7:0] tbl [8] = '{8'h00, 8'h11, 8'h22, 8'h21, 8'h0c, 8'h14,
                           8'h0a, 8'h00};
   logic [2:0] seq [8] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h0, 3'h7};
   logic [31:0] v;
   int errors = 0;
   int n_tests = 0;
   always #5 pclk = ~pclk;
   bcp_motor_model i_bcp_motor_model (.pclk(pclk), .target(hall_t),
      .hall_in(hall));
   bcp_predriver #(.PWM_PERIOD(PER), .LOCK_ON(200), .LOCK_OFF(400))
   i_bcp_predriver (.pclk(pclk), .presetn(presetn), .ce(ce),
      .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hall_in(hall), .direction(dir), .pulse_duty_input(pdi),
      .hall_output_select(sel), .current_limit_trip(trip),
      .supply_below_trip(below), .supply_above_recover(recov),
      .phase_a_high_drive(ah), .phase_b_high_drive(bh),
      .phase_c_high_drive(chh), .phase_a_low_drive(al),
      .phase_b_low_drive(bl), .phase_c_low_drive(cl),
      .hall_pulse_output(hp), .rotation_detect_oe(rot));
   task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp_dr(input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] ex(input logic [2:0] h);
      ex = {sel ? ^h : h[2], 1'b1, tbl[dir ? ~h : h][5:0]};
   endfunction
   task automatic w(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input logic [7:0] e);
      dq.push_back(e);
      smp <= 1'b1;
      @(posedge pclk);
      smp <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      int k;
      k = 0;
      rq.push_back(e);
      req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) errors++;
      req <= '0;
      @(posedge pclk);
   endtask
   task automatic duty(input int e);
      int c;
      c = 0;
      w(2 * PER);
      repeat (PER) begin
         @(posedge pclk);
         c += (bh === 1'b1);
      end
      cmp_rd(33'(e), 33'(c));
   endtask
   // monitor: each result appearing takes the oldest note
   always @(posedge pclk) begin
      if (pready === 1'b1 && rq.size() > 0)
         cmp_rd(rq.pop_front(), {pslverr, req.pwrite ? 32'h0 : prdata});
      if (smp)
         cmp_dr(dq.pop_front(), {hp, rot, ah, bh, chh, al, bl, cl});
   end
   initial begin
      repeat (30000) @(posedge pclk);
      errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(47113));
      repeat (3) @(posedge pclk);
      chk(8'h00);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, bcp_pkg::CTRL_OFS, 32'h0, {1'b0, bcp_pkg::CTRL_RST});
      apb(1'b0, bcp_pkg::VCTL_OFS, 32'h0, {21'h0, bcp_pkg::VCTL_RST});
      apb(1'b1, 8'h0c, 32'hffffffff, {1'b1, 32'h0});
      apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
      apb(1'b1, bcp_pkg::CTRL_OFS, 32'hfffffffe, 33'h0);
      apb(1'b0, bcp_pkg::CTRL_OFS, 32'h0, 33'h0);
      for (int i = 0; i < 3; i++) begin
         v = $urandom;
         apb(1'b1, bcp_pkg::VCTL_OFS, v, 33'h0);
         apb(1'b0, bcp_pkg::VCTL_OFS, 32'h0, {21'h0, v[11:0]});
      end
      apb(1'b1, bcp_pkg::VCTL_OFS, 32'hbb8, 33'h0);
      w(80);
      apb(1'b0, bcp_pkg::STAT_OFS, 32'h0, 33'h0d);
      $display("registers done");
      for (int d = 0; d < 2; d++) begin
         dir <= d[0];
         w(300);
         for (int i = 0; i < 8; i++) begin
            hall_t <= seq[i];
            sel <= 1'($urandom);
            w(80);
            chk(ex(seq[i]));
         end
      end
      hall_t <= 3'h5;
      w(80);
      dir <= 1'b0;
      w(30);
      chk(ex(3'h5) & 8'hc0);
      w(250);
      chk(ex(3'h5));
      $display("commutation done");
      pdi <= 1'b1;
      w(10);
      chk(ex(3'h5) & 8'hc7);
      pdi <= 1'b0;
      below <= 1'b1;
      recov <= 1'b0;
      w(10);
      chk(ex(3'h5) & 8'hc7);
      below <= 1'b0;
      w(10);
      chk(ex(3'h5) & 8'hc7);
      recov <= 1'b1;
      w(10);
      chk(ex(3'h5));
      $display("gating done");
      apb(1'b1, bcp_pkg::VCTL_OFS, 32'h546, 33'h0);
      duty(0);
      apb(1'b1, bcp_pkg::VCTL_OFS, 32'h87f, 33'h0);
      duty(PER / 2);
      while (bh !== 1'b0) @(posedge pclk);
      while (bh !== 1'b1) @(posedge pclk);
      trip <= 1'b1;
      w(40);
      trip <= 1'b0;
      w(20);
      chk(ex(3'h5));
      w(45);
      trip <= 1'b1;
      w(10);
      chk(ex(3'h5) & 8'hc7);
      trip <= 1'b0;
      apb(1'b1, bcp_pkg::VCTL_OFS, 32'hbb8, 33'h0);
      duty(PER);
      $display("duty done");
      hall_t <= 3'h2;
      w(80);
      hall_t <= 3'h5;
      w(60);
      apb(1'b1, bcp_pkg::CTRL_OFS, 32'h1, 33'h0);
      w(20);
      chk(ex(3'h5));
      w(200);
      chk(ex(3'h5) & 8'h87);
      w(400);
      chk(ex(3'h5) & 8'hbf);
      hall_t <= 3'h4;
      w(80);
      chk(ex(3'h4));
      $display("stall done");
      wrap_up();
   end
endmodule
`default_nettype wire
